// ==== hdl/dcf_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo #(
   parameter int unsigned WIDTH = 36,
   parameter int unsigned DEPTH = 8
)(
   input  wire logic                   clk_i,   // System clock
   input  wire logic                   rst_b_i, // Async reset
   input  wire logic                   clr_i,   // Synchronous flush
   dcf_stream_if.snk                   push,    // Filling side
   dcf_stream_if.src                   pop,     // Draining side
   output logic [$clog2(DEPTH):0]      count_o  // Words held
);

   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wptr_q;
   logic [AW:0]      rptr_q;

   wire              full  = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
   wire              empty = (wptr_q == rptr_q);
   wire              do_wr = push.valid && !full;
   wire              do_rd = pop.ready && !empty;

   assign push.ready = !full;
   assign pop.valid  = !empty;
   assign pop.data   = mem[rptr_q[AW-1:0]];
   assign count_o    = wptr_q - rptr_q;

   always_ff @(posedge clk_i)
   begin
      if (do_wr)
      begin
         mem[wptr_q[AW-1:0]] <= push.data;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wptr_q <= '0;
         rptr_q <= '0;
      end
      else if (clr_i)
      begin
         wptr_q <= '0;
         rptr_q <= '0;
      end
      else
      begin
         wptr_q <= wptr_q + (AW+1)'(do_wr);
         rptr_q <= rptr_q + (AW+1)'(do_rd);
      end
   end

endmodule

`default_nettype wire

// ==== hdl/dcf_pkg.sv ====
package dcf_pkg;

   // ------------------------------------------------------------
   // Widths and depth
   // ------------------------------------------------------------
   localparam int unsigned DATA_W = 36;
   localparam int unsigned BYTE_W = 9;
   localparam int unsigned WORD_W = 18;
   localparam int unsigned DEPTH  = 8;
   localparam int unsigned CNT_W  = 4;
   localparam int unsigned OFF_W  = 4;

   // ------------------------------------------------------------
   // Piece indices for bus matching
   // ------------------------------------------------------------
   localparam logic [1:0] LAST_LONG = 2'h0;
   localparam logic [1:0] LAST_WORD = 2'h1;
   localparam logic [1:0] LAST_BYTE = 2'h3;

   // ------------------------------------------------------------
   // Reset values and depth count
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_DATA  = 36'h0_0000_0000;
   localparam logic              RST_FLAG  = 1'b0;
   localparam logic              RST_CFG   = 1'b0;
   localparam logic [CNT_W-1:0]  DEPTH_CNT = 4'h8;

   // ------------------------------------------------------------
   // Pin sample vector layout
   // ------------------------------------------------------------
   localparam int unsigned PIN_W   = 56;
   localparam int unsigned P_DATA  = 0;
   localparam int unsigned P_AFOFF = 36;
   localparam int unsigned P_AEOFF = 40;
   localparam int unsigned P_SIZE  = 44;
   localparam int unsigned P_BM    = 45;
   localparam int unsigned P_ORDER = 46;
   localparam int unsigned P_MRST  = 47;
   localparam int unsigned P_RDB   = 48;
   localparam int unsigned P_WRA   = 49;
   localparam int unsigned P_GATEB = 50;
   localparam int unsigned P_GATEA = 51;
   localparam int unsigned P_CSB   = 52;
   localparam int unsigned P_CSA   = 53;
   localparam int unsigned P_PORT_B_CLOCK  = 54;
   localparam int unsigned P_PORT_A_CLOCK  = 55;

endpackage

// ==== hdl/dcf_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface dcf_stream_if;
   logic [dcf_pkg::DATA_W-1:0] data;
   logic                       valid;
   logic                       ready;

   modport src
   (
      output data,
      output valid,
      input  ready
   );

   modport snk
   (
      input  data,
      input  valid,
      output ready
   );
endinterface

`default_nettype wire

// ==== hdl/dcf_top.sv ====
// Functional notes
// - Almost-void low when words at/below offset
// - Almost-full low when free at/below offset
// - Both ports carry 36-bit two-way buses; port A reads return zeros and port B input is ignored
// - Order pin high at reset: big-endian
// - Order pin low at reset: little-endian
// - After reset pin picks timing mode
// - Bus-match low: 36 bits, else size pin
// - Port A transfers and flags on A edge
// - Port B transfers and flags on B edge
// - Works with related or unrelated port clocks
// - Port A bus floats while deselected
// - Port B bus floats while deselected
// - Standard mode: port B flag shows empty
// - Fall-through: port B flag shows valid output
// - Port A flag: full or space available
`timescale 1ns/1ps
`default_nettype none

module dcf_top
(
   input  wire logic        CLK_I,                      // System clock
   input  wire logic        RST_B_I,                    // Async reset, low
   input  wire logic        MASTER_RESET_ONE_B_I,       // Master reset pin, low
   input  wire logic        PORT_A_CLOCK_I,             // Port A clock pin
   input  wire logic        PORT_B_CLOCK_I,             // Port B clock pin
   input  wire logic        PORT_A_CHIP_SELECT_B_I,     // Port A select, low
   input  wire logic        PORT_B_CHIP_SELECT_B_I,     // Port B select, low
   input  wire logic        PORT_A_GATE_I,              // Port A enable
   input  wire logic        PORT_B_GATE_I,              // Port B enable
   input  wire logic        PORT_A_WRITE_I,             // Port A high write
   input  wire logic        PORT_B_READ_I,              // Port B high read
   input  wire logic        ORDER_TIMING_PIN_I,         // Order / timing select
   input  wire logic        BUS_MATCH_SELECT_I,         // Narrow bus enable
   input  wire logic        PORT_B_SIZE_I,              // High byte, low word
   input  wire logic [3:0]  ALMOST_VOID_OFFSET_I,       // Low-level threshold
   input  wire logic [3:0]  ALMOST_FULL_OFFSET_I,       // Full-margin threshold
   input  wire logic [35:0] PORT_A_BUS_I,               // Port A bus in
   output logic      [35:0] PORT_A_BUS_O,               // Port A bus out
   output logic             PORT_A_BUS_OE_O,            // Port A drive enable
   input  wire logic [35:0] PORT_B_BUS_I,               // Port B bus in
   output logic      [35:0] PORT_B_BUS_O,               // Port B bus out
   output logic             PORT_B_BUS_OE_O,            // Port B drive enable
   output logic             ALMOST_VOID_FLAG_O,         // Low when nearly empty
   output logic             ALMOST_FULL_FLAG_PORT_A_O,  // Low when nearly full
   output logic             VOID_OR_VALID_FLAG_O,       // Empty low / output valid
   output logic             FULL_OR_SPACE_FLAG_O        // Full low / space free
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [dcf_pkg::PIN_W-1:0] pin_m_q;
   logic [dcf_pkg::PIN_W-1:0] pin_s_q;
   logic                      port_a_clock_d_q;
   logic                      port_b_clock_d_q;

   wire [dcf_pkg::PIN_W-1:0] pin_raw = {PORT_A_CLOCK_I, PORT_B_CLOCK_I,
                                        PORT_A_CHIP_SELECT_B_I, PORT_B_CHIP_SELECT_B_I,
                                        PORT_A_GATE_I, PORT_B_GATE_I,
                                        PORT_A_WRITE_I, PORT_B_READ_I,
                                        MASTER_RESET_ONE_B_I, ORDER_TIMING_PIN_I,
                                        BUS_MATCH_SELECT_I, PORT_B_SIZE_I,
                                        ALMOST_VOID_OFFSET_I, ALMOST_FULL_OFFSET_I,
                                        PORT_A_BUS_I};

   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         pin_m_q  <= '0;
         pin_s_q  <= '0;
         port_a_clock_d_q <= 1'b0;
         port_b_clock_d_q <= 1'b0;
      end
      else
      begin
         pin_m_q  <= pin_raw;
         pin_s_q  <= pin_m_q;
         port_a_clock_d_q <= pin_s_q[dcf_pkg::P_PORT_A_CLOCK];
         port_b_clock_d_q <= pin_s_q[dcf_pkg::P_PORT_B_CLOCK];
      end
   end

   wire                           port_a_clock_s   = pin_s_q[dcf_pkg::P_PORT_A_CLOCK];
   wire                           port_b_clock_s   = pin_s_q[dcf_pkg::P_PORT_B_CLOCK];
   wire                           csa_b_s  = pin_s_q[dcf_pkg::P_CSA];
   wire                           csb_b_s  = pin_s_q[dcf_pkg::P_CSB];
   wire                           gate_a_s = pin_s_q[dcf_pkg::P_GATEA];
   wire                           gate_b_s = pin_s_q[dcf_pkg::P_GATEB];
   wire                           wr_a_s   = pin_s_q[dcf_pkg::P_WRA];
   wire                           rd_b_s   = pin_s_q[dcf_pkg::P_RDB];
   wire                           mrst_b_s = pin_s_q[dcf_pkg::P_MRST];
   wire                           order_s  = pin_s_q[dcf_pkg::P_ORDER];
   wire                           bm_s     = pin_s_q[dcf_pkg::P_BM];
   wire                           size_s   = pin_s_q[dcf_pkg::P_SIZE];
   wire [dcf_pkg::OFF_W-1:0]      ae_off_s = pin_s_q[dcf_pkg::P_AEOFF +: dcf_pkg::OFF_W];
   wire [dcf_pkg::OFF_W-1:0]      af_off_s = pin_s_q[dcf_pkg::P_AFOFF +: dcf_pkg::OFF_W];
   wire [dcf_pkg::DATA_W-1:0]     a_data_s = pin_s_q[dcf_pkg::P_DATA +: dcf_pkg::DATA_W];

   // ------------------------------------------------------------
   // Port clock edges
   // ------------------------------------------------------------
   // Each port has its own edge, so equal or unrelated clocks both work
   wire a_edge = port_a_clock_s && !port_a_clock_d_q;
   wire b_edge = port_b_clock_s && !port_b_clock_d_q;

   // ------------------------------------------------------------
   // Configuration caught during master reset
   // ------------------------------------------------------------
   logic big_q;
   logic bm_q;
   logic size_q;

   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         big_q  <= dcf_pkg::RST_CFG;
         bm_q   <= dcf_pkg::RST_CFG;
         size_q <= dcf_pkg::RST_CFG;
      end
      else if (!mrst_b_s)
      begin
         big_q  <= order_s;
         bm_q   <= bm_s;
         size_q <= size_s;
      end
   end

   // Same pin, read as timing select once reset is released
   wire fall_through_select = !order_s;

   // ------------------------------------------------------------
   // Transfer qualifiers
   // ------------------------------------------------------------
   wire a_wr = a_edge && !csa_b_s && gate_a_s && wr_a_s && mrst_b_s;
   wire b_rd = b_edge && !csb_b_s && gate_b_s && rd_b_s && mrst_b_s;

   // ------------------------------------------------------------
   // Buffer
   // ------------------------------------------------------------
   dcf_stream_if push_if ();
   dcf_stream_if pop_if ();

   logic [dcf_pkg::CNT_W-1:0] fifo_cnt;

   assign push_if.data  = a_data_s;

   dcf_fifo #(
      .WIDTH (dcf_pkg::DATA_W),
      .DEPTH (dcf_pkg::DEPTH)
   ) u_fifo (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .clr_i   (!mrst_b_s),
      .push    (push_if.snk),
      .pop     (pop_if.src),
      .count_o (fifo_cnt)
   );

   // ------------------------------------------------------------
   // Staging word and bus matching
   // ------------------------------------------------------------
   logic [dcf_pkg::DATA_W-1:0] st_q;
   logic                       st_vld_q;
   logic [1:0]                 idx_q;
   logic [dcf_pkg::DATA_W-1:0] b_out_q;
   logic                       vov_q;

   assign pop_if.ready = !st_vld_q && mrst_b_s;

   wire [1:0] last_idx = !bm_q ? dcf_pkg::LAST_LONG :
                         size_q ? dcf_pkg::LAST_BYTE : dcf_pkg::LAST_WORD;
   wire [1:0] sel      = big_q ? (last_idx - idx_q) : idx_q;
   wire       at_last  = (idx_q == last_idx);

   wire [dcf_pkg::BYTE_W-1:0] byte_pc = st_q[sel*dcf_pkg::BYTE_W +: dcf_pkg::BYTE_W];
   wire [dcf_pkg::WORD_W-1:0] word_pc = st_q[sel[0]*dcf_pkg::WORD_W +: dcf_pkg::WORD_W];
   wire [dcf_pkg::DATA_W-1:0] piece   = !bm_q ? st_q :
                                        size_q ? {27'h000_0000, byte_pc} :
                                                 {18'h0_0000, word_pc};

   // Fall-through prefetches into the output register
   wire take = fall_through_select ? (b_edge && mrst_b_s && st_vld_q && (!vov_q || b_rd))
                    : (b_rd && st_vld_q);
   wire load = pop_if.valid && pop_if.ready;

   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         st_q     <= dcf_pkg::RST_DATA;
         st_vld_q <= 1'b0;
         idx_q    <= 2'h0;
         b_out_q  <= dcf_pkg::RST_DATA;
      end
      else if (!mrst_b_s)
      begin
         st_vld_q <= 1'b0;
         idx_q    <= 2'h0;
         b_out_q  <= dcf_pkg::RST_DATA;
      end
      else
      begin
         if (load)
         begin
            st_q     <= pop_if.data;
            st_vld_q <= 1'b1;
         end
         else if (take && at_last)
         begin
            st_vld_q <= 1'b0;
         end
         if (take)
         begin
            b_out_q <= piece;
            idx_q   <= at_last ? 2'h0 : idx_q + 2'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Flag counts
   // ------------------------------------------------------------
   // Pointer difference plus the staging word, seen by each port only at its own edge
   wire [dcf_pkg::CNT_W-1:0] words     = fifo_cnt + dcf_pkg::CNT_W'(st_vld_q);
   // Staging word counts against capacity, so words plus free stays at depth
   wire [dcf_pkg::CNT_W-1:0] free_now  = dcf_pkg::DEPTH_CNT - words;
   wire                      acc_wr    = a_wr && push_if.ready && (free_now != '0);
   wire [dcf_pkg::CNT_W-1:0] free_aft  = free_now - dcf_pkg::CNT_W'(acc_wr);
   wire                      data_next = (st_vld_q && !(take && at_last)) || pop_if.valid;
   wire                      vov_d     = fall_through_select ? (take || (vov_q && !b_rd)) : data_next;

   assign push_if.valid = acc_wr;

   // ------------------------------------------------------------
   // Flags and output registers
   // ------------------------------------------------------------
   logic ae_q;
   logic af_q;
   logic fs_q;
   logic a_oe_q;
   logic b_oe_q;

   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         ae_q   <= dcf_pkg::RST_FLAG;
         af_q   <= dcf_pkg::RST_FLAG;
         fs_q   <= dcf_pkg::RST_FLAG;
         vov_q  <= dcf_pkg::RST_FLAG;
         a_oe_q <= 1'b0;
         b_oe_q <= 1'b0;
      end
      else
      begin
         a_oe_q <= !csa_b_s && !wr_a_s;
         b_oe_q <= !csb_b_s && rd_b_s;
         if (!mrst_b_s)
         begin
            ae_q  <= dcf_pkg::RST_FLAG;
            af_q  <= dcf_pkg::RST_FLAG;
            fs_q  <= dcf_pkg::RST_FLAG;
            vov_q <= dcf_pkg::RST_FLAG;
         end
         else
         begin
            if (a_edge)
            begin
               af_q <= (free_aft > af_off_s);
               fs_q <= (free_aft != '0);
            end
            if (b_edge)
            begin
               ae_q  <= (words > ae_off_s);
               vov_q <= vov_d;
            end
         end
      end
   end

   // Port A reads carry no FIFO data
   assign PORT_A_BUS_O              = dcf_pkg::RST_DATA;
   assign PORT_A_BUS_OE_O           = a_oe_q;
   assign PORT_B_BUS_O              = b_out_q;
   assign PORT_B_BUS_OE_O           = b_oe_q;
   assign ALMOST_VOID_FLAG_O        = ae_q;
   assign ALMOST_FULL_FLAG_PORT_A_O = af_q;
   assign VOID_OR_VALID_FLAG_O      = vov_q;
   assign FULL_OR_SPACE_FLAG_O      = fs_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_B_I);

   a_void_level:     assert property (b_edge && mrst_b_s |=> ALMOST_VOID_FLAG_O == ($past(words) > $past(ae_off_s)))
                        else $error("almost-void flag wrong after B edge");
   a_full_margin:    assert property (a_edge && mrst_b_s |=> ALMOST_FULL_FLAG_PORT_A_O == ($past(free_aft) > $past(af_off_s)))
                        else $error("almost-full flag wrong after A edge");
   a_a_float:        assert property (csa_b_s |=> !PORT_A_BUS_OE_O)
                        else $error("port A driven while deselected");
   a_b_float:        assert property (csb_b_s |=> !PORT_B_BUS_OE_O)
                        else $error("port B driven while deselected");
   a_order_caught:   assert property (!mrst_b_s ##1 mrst_b_s |-> big_q == $past(order_s, 2))
                        else $error("byte order not caught at reset");
   a_b_flag_hold:    assert property (mrst_b_s && $past(mrst_b_s) && !$past(b_edge) |-> $stable(VOID_OR_VALID_FLAG_O))
                        else $error("port B flag moved without B edge");
   a_std_empty:      assert property (b_edge && mrst_b_s && !fall_through_select && !st_vld_q && !pop_if.valid |=> !VOID_OR_VALID_FLAG_O)
                        else $error("empty not shown in standard mode");
   a_fall_through_select_fill:      assert property (b_edge && mrst_b_s && fall_through_select && st_vld_q && !vov_q |=> VOID_OR_VALID_FLAG_O ##0 PORT_B_BUS_O == $past(piece))
                        else $error("fall-through word not presented");
   a_space_flag:     assert property (a_edge && mrst_b_s && words == dcf_pkg::DEPTH_CNT |=> !FULL_OR_SPACE_FLAG_O)
                        else $error("space shown while full");
   a_long_word:      assert property (take && !bm_q |=> PORT_B_BUS_O == $past(st_q))
                        else $error("long word not passed whole");

endmodule

`default_nettype wire

// ==== sim/dcf_agent.sv ====
`timescale 1ns/1ps
`default_nettype none

module dcf_agent
(
   input  wire logic        clk_i,    // System clock
   input  wire logic        same_i,   // Share one port clock
   output logic             port_a_clock_o,   // Port A clock
   output logic             port_b_clock_o,   // Port B clock
   output logic             csa_b_o,  // Port A select, low
   output logic             csb_b_o,  // Port B select, low
   output logic             gate_a_o, // Port A enable
   output logic             gate_b_o, // Port B enable
   output logic             wr_o,     // Port A write
   output logic             rd_o,     // Port B read
   output logic [35:0]      bus_a_o,  // Port A data
   input  wire logic [35:0] bus_b_i,  // Port B data
   input  wire logic        oe_b_i    // Port B drive enable
);
   logic port_b_clock_q;

   // ------------------------------------------------------------
   // Free-running port clocks, phase unrelated to the system clock
   // ------------------------------------------------------------
   initial
   begin
      {csa_b_o, csb_b_o, gate_a_o, gate_b_o, wr_o, rd_o} = 6'h30;
      bus_a_o = 36'h0_0000_0000;
      port_a_clock_o  = 1'b0;
      #33;
      forever #400 port_a_clock_o = ~port_a_clock_o;
   end

   initial
   begin
      port_b_clock_q = 1'b0;
      #171;
      forever #400 port_b_clock_q = ~port_b_clock_q;
   end

   assign port_b_clock_o = same_i ? port_a_clock_o : port_b_clock_q;

   task automatic wr(input logic [35:0] d);
      @(negedge port_a_clock_o);
      @(posedge clk_i);
      csa_b_o  <= 1'b0;
      gate_a_o <= 1'b1;
      wr_o     <= 1'b1;
      bus_a_o  <= d;
      @(posedge port_a_clock_o);
      repeat (6) @(posedge clk_i);
      csa_b_o  <= 1'b1;
      gate_a_o <= 1'b0;
      wr_o     <= 1'b0;
      bus_a_o  <= ~d;
   endtask

   task automatic rd(output logic [35:0] d, output logic oe);
      @(negedge port_b_clock_o);
      @(posedge clk_i);
      csb_b_o  <= 1'b0;
      gate_b_o <= 1'b1;
      rd_o     <= 1'b1;
      @(posedge port_b_clock_o);
      repeat (6) @(posedge clk_i);
      d  = bus_b_i;
      oe = oe_b_i;
      csb_b_o  <= 1'b1;
      gate_b_o <= 1'b0;
      rd_o     <= 1'b0;
   endtask
endmodule

`default_nettype wire

// ==== sim/dcf_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module dcf_top_tb;
   logic        clk = 1'b0;
   logic        rst_b, mr_b, order, bm, size, same;
   logic        port_a_clock, port_b_clock, csa_b, csb_b, ga, gb, wr, rd, oe_a, oe_b, av, af, vv, fs, oe;
   logic [35:0] bus_a, bus_ao, bus_bo, got;
   int          error_cnt = 0;
   int          tests_run = 0;

   always #50 clk = ~clk;

   dcf_top i_dut (.CLK_I(clk), .RST_B_I(rst_b), .MASTER_RESET_ONE_B_I(mr_b),
      .PORT_A_CLOCK_I(port_a_clock), .PORT_B_CLOCK_I(port_b_clock), .PORT_A_CHIP_SELECT_B_I(csa_b),
      .PORT_B_CHIP_SELECT_B_I(csb_b), .PORT_A_GATE_I(ga), .PORT_B_GATE_I(gb),
      .PORT_A_WRITE_I(wr), .PORT_B_READ_I(rd), .ORDER_TIMING_PIN_I(order),
      .BUS_MATCH_SELECT_I(bm), .PORT_B_SIZE_I(size), .ALMOST_VOID_OFFSET_I(4'h2),
      .ALMOST_FULL_OFFSET_I(4'h2), .PORT_A_BUS_I(bus_a), .PORT_A_BUS_O(bus_ao),
      .PORT_A_BUS_OE_O(oe_a), .PORT_B_BUS_I(36'h0_0000_0000), .PORT_B_BUS_O(bus_bo),
      .PORT_B_BUS_OE_O(oe_b), .ALMOST_VOID_FLAG_O(av), .ALMOST_FULL_FLAG_PORT_A_O(af),
      .VOID_OR_VALID_FLAG_O(vv), .FULL_OR_SPACE_FLAG_O(fs));

   dcf_agent i_agt (.clk_i(clk), .same_i(same), .port_a_clock_o(port_a_clock), .port_b_clock_o(port_b_clock),
      .csa_b_o(csa_b), .csb_b_o(csb_b), .gate_a_o(ga), .gate_b_o(gb), .wr_o(wr),
      .rd_o(rd), .bus_a_o(bus_a), .bus_b_i(bus_bo), .oe_b_i(oe_b));

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic end_sim;
      if (error_cnt == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic mrst(input logic be, input logic b_m, input logic sz, input logic tm);
      @(posedge clk);
      mr_b  <= 1'b0;
      order <= be;
      bm    <= b_m;
      size  <= sz;
      repeat (40) @(posedge clk); // Five periods of each port clock
      mr_b <= 1'b1;
      repeat (5) @(posedge clk);
      order <= tm; // Static from here on
      repeat (20) @(posedge clk);
   endtask

   task automatic flags(input int n);
      repeat (2) @(posedge port_b_clock);
      repeat (2) @(posedge port_a_clock);
      repeat (6) @(posedge clk);
      `CHK(av, n > 2);
      `CHK(af, (8 - n) > 2);
      `CHK(fs, n < 8);
      `CHK(vv, n > 0);
   endtask

   task automatic fill_drain;
      mrst(1'b1, 1'b0, 1'b0, 1'b1);
      `CHK(oe_a, 1'b0);
      `CHK(bus_ao, 36'h0_0000_0000);
      `CHK(oe_b, 1'b0);
      flags(0);
      for (int i = 1; i <= 9; i++)
      begin
         i_agt.wr(36'h9_8765_4320 + 36'(i));
         flags(i > 8 ? 8 : i);
      end
      for (int i = 1; i <= 9; i++)
      begin
         i_agt.rd(got, oe);
         if (i < 9)
         begin
            `CHK(got, 36'h9_8765_4320 + 36'(i));
            `CHK(oe, 1'b1);
         end
         flags(i > 8 ? 0 : 8 - i);
      end
   endtask

   task automatic narrow;
      logic [35:0] w, m;
      int          wd;
      for (int c = 0; c < 4; c++)
      begin
         wd = c[1] ? 9 : 18;
         m  = c[1] ? 36'h0_0000_01FF : 36'h0_0003_FFFF;
         w  = 36'hA_BCDE_F012 ^ 36'(c);
         mrst(c[0], 1'b1, c[1], 1'b1);
         i_agt.wr(w);
         repeat (2) @(posedge port_b_clock);
         for (int k = 0; k < 36 / wd; k++)
         begin
            i_agt.rd(got, oe);
            `CHK(got, (c[0] ? w >> (36 - wd * (k + 1)) : w >> (wd * k)) & m);
         end
      end
   endtask

   task automatic fall_through;
      same <= 1'b1;
      mrst(1'b0, 1'b0, 1'b0, 1'b0);
      i_agt.wr(36'h5_A5A5_A5A5);
      repeat (2) @(posedge port_b_clock);
      repeat (6) @(posedge clk);
      `CHK(vv, 1'b1);
      `CHK(bus_bo, 36'h5_A5A5_A5A5);
      i_agt.rd(got, oe);
      `CHK(got, 36'h5_A5A5_A5A5);
      repeat (2) @(posedge port_b_clock);
      repeat (6) @(posedge clk);
      `CHK(vv, 1'b0);
      `CHK(fs, 1'b1);
   endtask

   initial
   begin
      {rst_b, mr_b, order, bm, size, same} = 6'h10;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      fill_drain;
      narrow;
      fall_through;
      end_sim;
   end

   initial
   begin
      #3_000_000; // About twenty times the expected run
      error_cnt++;
      end_sim;
   end
endmodule

`default_nettype wire
